// File: rtl/clock_unit_regs.svh
/*
  Register offsets, field positions, reset values and widths of the clock
  unit status and interrupt-enable bank.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef CLOCK_UNIT_REGS_SVH
`define CLOCK_UNIT_REGS_SVH

// ----------------------------------------------------------------------
// Register indices and byte addresses (index times four).
// ----------------------------------------------------------------------
`define CU_ADDR_W          12
`define CU_STATUS_IDX      10'h037
`define CU_ENABLE_IDX      10'h038
`define CU_STATUS_ADDR     {`CU_STATUS_IDX, 2'b00}
`define CU_ENABLE_ADDR     {`CU_ENABLE_IDX, 2'b00}

// ----------------------------------------------------------------------
// Field positions, shared by both registers where they line up.
// ----------------------------------------------------------------------
`define CU_TICK_BIT        7
`define CU_POR_BIT         6
`define CU_BOR_BIT         5
`define CU_PLLCHG_BIT      4
`define CU_LOCK_BIT        3
`define CU_BADADDR_BIT     2
`define CU_XCHG_BIT        1
`define CU_QUAL_BIT        0

// ----------------------------------------------------------------------
// Reset values and divider figures.
// ----------------------------------------------------------------------
`define CU_POR_RESET       1'b1
`define CU_BOR_RESET       1'b1
`define CU_BADADDR_RESET   1'b0
`define CU_ENABLE_RESET    3'h0
`define CU_PLL_OUTPUT_DIVIDER_W       5
`define CU_RATIO_W         6
`define CU_UNLOCK_RATIO    6'h04
`define CU_BUS_RATIO       2'h2
`define CU_RESP_OKAY       2'h0
`define CU_RESP_SLVERR     2'h2

`endif

// File: rtl/clock_unit_pkg.sv
/*
  Types of the clock unit status bank: bus state, register select and the
  packed state record of the design module.
  Assumes the constants header is on the include path.
*/
`include "clock_unit_regs.svh"

package clock_unit_pkg;

  // ----------------------------------------------------------------------
  // Bus slave states and register select.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRESP = 2'b01,
    BUS_RDATA = 2'b10
  } bus_state_t;

  typedef enum logic [1:0] {
    SEL_NONE   = 2'b00,
    SEL_STATUS = 2'b01,
    SEL_ENABLE = 2'b10
  } reg_sel_t;

  // Sticky flags that software clears by writing ones.
  typedef struct packed {
    logic tick;
    logic powerup;
    logic brownout;
    logic pll_chg;
    logic bad_addr;
    logic xtal_chg;
  } flags_t;

  // Interrupt enables.
  typedef struct packed {
    logic tick;
    logic pll;
    logic xtal;
  } enables_t;

  // Whole state of the design module.
  typedef struct packed {
    bus_state_t                     bus_st;
    logic                           aw_got;
    logic                           w_got;
    logic [`CU_ADDR_W-1:0]          waddr;
    logic [7:0]                     wdata;
    logic                           wlane;
    logic [1:0]                     bresp;
    logic [7:0]                     rdata;
    logic [1:0]                     rresp;
    flags_t                         flags;
    enables_t                       en;
    logic [2:0]                     lock_sync;
    logic                           lock_filt;
    logic                           lock_hold;
    logic                           lock;
    logic [2:0]                     qual_sync;
    logic                           qual_filt;
    logic                           qual_hold;
    logic                           qual;
    logic [`CU_RATIO_W-1:0]         pll_ratio;
    logic                           bus_from_pll;
    logic                           pll_run;
  } state_t;

endpackage

// File: rtl/clock_unit_status.sv
/*
  Status flags and interrupt enables of a clock, reset and power unit,
  reached over an AXI4-Lite slave port.
  Assumes: lock and oscillator-qualified levels arrive from analog logic
  outside this clock; tick, reset-cause, stop-mode and configuration-write
  strobes come from logic on aclk. aresetn is the power-on reset and
  sys_reset_n the ordinary system reset.
  Only byte lane 0 of a write acts.
*/
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps

`include "clock_unit_regs.svh"

module clock_unit_status
  import clock_unit_pkg::*;
(
  // Clock and resets.
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      sys_reset_n,
  // AXI4-Lite write address and data.
  input  wire logic [`CU_ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [`CU_ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Event and reset-cause strobes from logic on aclk.
  input  wire logic                      periodic_tick_timeout,
  input  wire logic                      lowvolt_reset_event,
  input  wire logic                      bad_address_reset_event,
  // Mode and configuration strobes from logic on aclk.
  input  wire logic                      full_stop_entry,
  input  wire logic                      pseudo_stop_entry,
  input  wire logic                      synth_config_write,
  input  wire logic                      pll_source_select,
  input  wire logic [`CU_PLL_OUTPUT_DIVIDER_W-1:0]  pll_output_divider,
  // Asynchronous levels from the PLL and oscillator monitor.
  input  wire logic                      pll_lock_raw,
  input  wire logic                      xtal_qualified_raw,
  // Clock steering outputs.
  output logic [`CU_RATIO_W-1:0]         pll_divide_ratio,
  output logic                           bus_half_of_pll,
  output logic                           xtal_clock_enable,
  output logic                           pll_run,
  // Interrupt requests.
  output logic                           periodic_tick_irq,
  output logic                           pll_settle_irq,
  output logic                           xtal_change_irq
);

  // ----------------------------------------------------------------------
  // Decode and reset constant.
  // ----------------------------------------------------------------------

  // Word-aligned match; low address bits are ignored as usual for AXI-Lite.
  // Registers live in byte lane 0.
  function automatic reg_sel_t decode(input logic [`CU_ADDR_W-1:0] addr);
    logic [`CU_ADDR_W-1:0] word;
    word = {addr[`CU_ADDR_W-1:2], 2'b00};

    if (word == `CU_STATUS_ADDR) begin
      decode = SEL_STATUS;
    end else if (word == `CU_ENABLE_ADDR) begin
      decode = SEL_ENABLE;
    end else begin
      decode = SEL_NONE;
    end
  endfunction

  // Power-on values; the PLL run request is up from the first cycle.
  // Lock and qualified start low, the safe side.
  localparam state_t ST_RESET = '{
    bus_st:       BUS_IDLE,
    flags:        '{tick: 1'b0, powerup: `CU_POR_RESET, brownout: `CU_BOR_RESET,
                    pll_chg: 1'b0, bad_addr: `CU_BADADDR_RESET, xtal_chg: 1'b0},
    en:           `CU_ENABLE_RESET,
    pll_ratio:    `CU_UNLOCK_RATIO,
    pll_run:      1'b1,
    default:      '0
  };

  // Registered state and its next value.
  state_t st_q;
  state_t st_d;

  // ----------------------------------------------------------------------
  // Read-back views of the two registers.
  // ----------------------------------------------------------------------

  // Views feed the read data only.
  logic [7:0] status_view;
  logic [7:0] enable_view;

  // Bit layout is shared with the write path through the header positions.
  always_comb begin
    status_view                  = 8'h00;
    status_view[`CU_TICK_BIT]    = st_q.flags.tick;
    status_view[`CU_POR_BIT]     = st_q.flags.powerup;
    status_view[`CU_BOR_BIT]     = st_q.flags.brownout;
    status_view[`CU_PLLCHG_BIT]  = st_q.flags.pll_chg;
    // Live levels sit at bits 3 and 0.
    status_view[`CU_LOCK_BIT]    = st_q.lock;
    status_view[`CU_BADADDR_BIT] = st_q.flags.bad_addr;
    status_view[`CU_XCHG_BIT]    = st_q.flags.xtal_chg;
    status_view[`CU_QUAL_BIT]    = st_q.qual;

    // Enables read back as written.
    enable_view                  = 8'h00;
    enable_view[`CU_TICK_BIT]    = st_q.en.tick;
    enable_view[`CU_PLLCHG_BIT]  = st_q.en.pll;
    enable_view[`CU_XCHG_BIT]    = st_q.en.xtal;
  end

  // ----------------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------------

  // Handshake terms and write controls.
  logic       aw_take;
  logic       w_take;
  logic       ar_take;
  logic       do_write;
  reg_sel_t   wsel;
  reg_sel_t   rsel;
  // Ones written to the status word.
  logic [7:0] w1c;
  logic       qual_clear;

  // Address and data are taken in either order; a read waits for any
  // half-taken write, so one access at a time ever touches the registers.
  // This costs a cycle only when a read follows a write.
  assign s_axi_awready = (st_q.bus_st == BUS_IDLE) && !st_q.aw_got;
  assign s_axi_wready  = (st_q.bus_st == BUS_IDLE) && !st_q.w_got;
  assign s_axi_arready = (st_q.bus_st == BUS_IDLE) && !st_q.aw_got && !st_q.w_got;
  // A channel moves when valid meets ready.
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  always_comb begin
    st_d       = st_q;
    do_write   = 1'b0;
    wsel       = SEL_NONE;
    rsel       = decode(s_axi_araddr);
    w1c        = 8'h00;
    qual_clear = 1'b0;

    // Bus channel capture.
    if (aw_take) begin
      st_d.aw_got = 1'b1;
      st_d.waddr  = s_axi_awaddr;
    end

    // Only lane 0 and its strobe count.
    if (w_take) begin
      st_d.w_got = 1'b1;
      st_d.wdata = s_axi_wdata[7:0];
      st_d.wlane = s_axi_wstrb[0];
    end

    // Bus sequencing; the write lands the cycle after both halves are held.
    // A read answers in the next cycle.
    case (st_q.bus_st)
      BUS_IDLE: begin
        if (st_q.aw_got && st_q.w_got) begin
          // Both halves held: write now.
          do_write    = 1'b1;
          wsel        = decode(st_q.waddr);
          st_d.aw_got = 1'b0;
          st_d.w_got  = 1'b0;
          st_d.bresp  = (wsel == SEL_NONE) ? `CU_RESP_SLVERR : `CU_RESP_OKAY;
          st_d.bus_st = BUS_WRESP;
        end else if (ar_take) begin
          // Data is frozen until rready.
          st_d.rresp  = (rsel == SEL_NONE) ? `CU_RESP_SLVERR : `CU_RESP_OKAY;
          st_d.rdata  = (rsel == SEL_STATUS) ? status_view :
                        (rsel == SEL_ENABLE) ? enable_view : 8'h00;
          st_d.bus_st = BUS_RDATA;
        end
      end

      // The answer stands until bready.
      BUS_WRESP: begin
        if (s_axi_bready) begin
          st_d.bus_st = BUS_IDLE;
        end
      end

      // Data stands until rready.
      BUS_RDATA: begin
        if (s_axi_rready) begin
          st_d.bus_st = BUS_IDLE;
        end
      end

      // Unused code: back to idle.
      default: begin
        st_d.bus_st = BUS_IDLE;
      end
    endcase

    // Register writes; only byte lane 0 carries the eight register bits.
    if (do_write && st_q.wlane) begin
      if (wsel == SEL_STATUS) begin
        w1c = st_q.wdata;
      end

      // Enables change at any time.
      if (wsel == SEL_ENABLE) begin
        st_d.en.tick = st_q.wdata[`CU_TICK_BIT];
        st_d.en.pll  = st_q.wdata[`CU_PLLCHG_BIT];
        st_d.en.xtal = st_q.wdata[`CU_XCHG_BIT];
      end
    end

    // Three-stage synchronisers; a change counts once stages two and three
    // agree, which also rejects a single-cycle glitch on the analog levels.
    // Only stage one sees the raw pin.
    st_d.lock_sync = {st_q.lock_sync[1:0], pll_lock_raw};
    st_d.qual_sync = {st_q.qual_sync[1:0], xtal_qualified_raw};

    // Lock level.
    if (st_q.lock_sync[1] == st_q.lock_sync[2]) begin
      st_d.lock_filt = st_q.lock_sync[2];
    end

    // Qualified level.
    if (st_q.qual_sync[1] == st_q.qual_sync[2]) begin
      st_d.qual_filt = st_q.qual_sync[2];
    end

    // A synthesiser write forces lock low until the PLL itself drops lock,
    // so a stale high from before the retune is never reported.
    // It falls once real lock is lost.
    st_d.lock_hold = synth_config_write || (st_q.lock_hold && st_d.lock_filt);
    // Reported lock unless held.
    st_d.lock      = st_d.lock_filt && !st_d.lock_hold;

    // Qualification depends on the VCO, so losing lock loses it as well.
    // Pseudo stop keeps the oscillator up.
    qual_clear = full_stop_entry
               || synth_config_write
               || (st_q.lock && !st_d.lock && !pseudo_stop_entry);

    // Held low until the level falls.
    st_d.qual_hold = qual_clear || (st_q.qual_hold && st_d.qual_filt);
    st_d.qual      = st_d.qual_filt && !st_d.qual_hold;

    // Sticky flags: a set in the same cycle as a clear wins.
    // A lost event is worse than one extra interrupt.

    // Tick timer period end.
    st_d.flags.tick     = (st_q.flags.tick && !w1c[`CU_TICK_BIT])
                        || periodic_tick_timeout;

    // Only power-on reset sets it.
    st_d.flags.powerup  = st_q.flags.powerup && !w1c[`CU_POR_BIT];

    // Low-voltage event.
    st_d.flags.brownout = (st_q.flags.brownout && !w1c[`CU_BOR_BIT])
                        || lowvolt_reset_event;

    // Either edge of the reported lock.
    st_d.flags.pll_chg  = (st_q.flags.pll_chg && !w1c[`CU_PLLCHG_BIT])
                        || (st_d.lock != st_q.lock);

    // Illegal-address event.
    st_d.flags.bad_addr = (st_q.flags.bad_addr && !w1c[`CU_BADADDR_BIT])
                        || bad_address_reset_event;

    // Either edge of the qualified status.
    st_d.flags.xtal_chg = (st_q.flags.xtal_chg && !w1c[`CU_XCHG_BIT])
                        || (st_d.qual != st_q.qual);

    // Output clock ratio: fixed divide-by-four until lock protects the core
    // from an overshooting VCO during settling.
    // A new divider acts one cycle later.
    if (st_d.lock) begin
      st_d.pll_ratio = `CU_RATIO_W'(pll_output_divider) + `CU_RATIO_W'(1);
    end else begin
      st_d.pll_ratio = `CU_UNLOCK_RATIO;
    end

    // Steering levels, registered.
    st_d.bus_from_pll = pll_source_select;
    // Qualification needs the VCO.
    st_d.pll_run      = 1'b1;

    // A system reset restarts everything but the reset-cause flags, which
    // must survive it so software can tell why the part restarted.
    // A cut bus transfer is dropped.
    if (!sys_reset_n) begin
      st_d                = ST_RESET;
      // Old causes kept, new ones added.
      st_d.flags.powerup  = st_q.flags.powerup;
      st_d.flags.brownout = st_q.flags.brownout || lowvolt_reset_event;
      st_d.flags.bad_addr = st_q.flags.bad_addr || bad_address_reset_event;
    end
  end

  // ----------------------------------------------------------------------
  // State register; aresetn is the power-on reset.
  // ----------------------------------------------------------------------

  // Power-on sets powerup and brownout and clears bad-address.
  // One record keeps all fields in step.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------

  // Bus answers come straight from the state record.
  // Upper data bits read zero.
  assign s_axi_bvalid = (st_q.bus_st == BUS_WRESP);
  assign s_axi_bresp  = st_q.bresp;
  assign s_axi_rvalid = (st_q.bus_st == BUS_RDATA);
  assign s_axi_rdata  = {24'h000000, st_q.rdata};
  assign s_axi_rresp  = st_q.rresp;

  // Clock steering.
  // Registered, so glitch free.
  assign pll_divide_ratio  = st_q.pll_ratio;
  assign bus_half_of_pll   = st_q.bus_from_pll;
  assign xtal_clock_enable = st_q.qual;
  assign pll_run           = st_q.pll_run;

  // Level requests that fall as soon as flag or enable is cleared.
  // No separate clear is needed.
  assign periodic_tick_irq = st_q.flags.tick && st_q.en.tick;
  assign pll_settle_irq    = st_q.flags.pll_chg && st_q.en.pll;
  assign xtal_change_irq   = st_q.flags.xtal_chg && st_q.en.xtal;

endmodule

// File: test/clock_unit_status_assertions.sv
/*
  Port-level checker of the clock unit status bank.
  Assumes it is bound to clock_unit_status; one clock, two resets.
*/
`timescale 1ns/100ps

module clock_unit_status_checker (
  // Clock and resets.
  input logic       aclk,
  input logic       aresetn,
  input logic       sys_reset_n,
  // Register bus handshakes.
  input logic       s_axi_awvalid,
  input logic       s_axi_awready,
  input logic       s_axi_wvalid,
  input logic       s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic       s_axi_bvalid,
  input logic       s_axi_bready,
  input logic       s_axi_arvalid,
  input logic       s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic       s_axi_rvalid,
  input logic       s_axi_rready,
  // Modes and clock steering.
  input logic       full_stop_entry,
  input logic       synth_config_write,
  input logic       pll_source_select,
  input logic [4:0] pll_output_divider,
  input logic [5:0] pll_divide_ratio,
  input logic       bus_half_of_pll,
  input logic       xtal_clock_enable,
  input logic       pll_run
);
  // ----------------------------------------------------------------------
  // Properties, all on aclk; either reset silences them.
  // ----------------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !sys_reset_n);

  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response not on time");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not on time");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped early");
  ratio_value_a: assert property (
    $past(aresetn) && $past(sys_reset_n) |-> pll_divide_ratio == 6'h04
    || pll_divide_ratio == {1'b0, $past(pll_output_divider)} + 6'h01)
    else $error("divide ratio wrong");
  bus_half_a: assert property (
    $past(aresetn) && $past(sys_reset_n) |-> bus_half_of_pll == $past(pll_source_select))
    else $error("bus clock source wrong");
  full_stop_a: assert property (
    full_stop_entry |-> ##[1:2] !xtal_clock_enable) else $error("stop kept oscillator");
  synth_clear_a: assert property (
    synth_config_write |-> ##[1:3] (pll_divide_ratio == 6'h04 && !xtal_clock_enable))
    else $error("config write kept lock");
  pll_run_a: assert property (pll_run)
    else $error("pll stopped");
endmodule

bind clock_unit_status clock_unit_status_checker u_clock_unit_status_checker (
  .aclk(aclk), .aresetn(aresetn), .sys_reset_n(sys_reset_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .full_stop_entry(full_stop_entry), .synth_config_write(synth_config_write),
  .pll_source_select(pll_source_select), .pll_output_divider(pll_output_divider),
  .pll_divide_ratio(pll_divide_ratio), .bus_half_of_pll(bus_half_of_pll),
  .xtal_clock_enable(xtal_clock_enable), .pll_run(pll_run));

// File: test/clock_unit_status_test.sv
/*
  Self-checking bench of the clock unit status bank.
  Assumes header, package and design are compiled before it.
*/
`timescale 1ns/100ps
`include "clock_unit_regs.svh"

module clock_unit_status_test;
  logic        aclk, aresetn, sys_reset_n;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        tick, lowvolt, badaddr, fstop, pstop, synth, psel, lock_raw, qual_raw;
  logic [4:0]  div;
  logic [5:0]  ratio;
  logic        bus_half, xen, prun, tick_irq, pll_irq, x_irq;
  int          err_total, n_checks;

  clock_unit_status u_clock_unit_status (
    .aclk(aclk), .aresetn(aresetn), .sys_reset_n(sys_reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .periodic_tick_timeout(tick), .lowvolt_reset_event(lowvolt),
    .bad_address_reset_event(badaddr), .full_stop_entry(fstop),
    .pseudo_stop_entry(pstop), .synth_config_write(synth), .pll_source_select(psel),
    .pll_output_divider(div), .pll_lock_raw(lock_raw), .xtal_qualified_raw(qual_raw),
    .pll_divide_ratio(ratio), .bus_half_of_pll(bus_half), .xtal_clock_enable(xen),
    .pll_run(prun), .periodic_tick_irq(tick_irq), .pll_settle_irq(pll_irq),
    .xtal_change_irq(x_irq));

  // ----------------------------------------------------------------------
  // Clock, comparison, verdict and bus tasks.
  // ----------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // A wait that used up its bound ends the run at once.
  task automatic stall(input int n);
    if (n >= 40) begin
      err_total++;
      summarize();
    end
  endtask

  // Ready is raised only after valid, so the hold of the answer is exercised.
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h0, d};
    wstrb   <= s;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready) && n < 40);
    bready <= 1'b0;
    check("bresp", {30'h0, bresp}, {30'h0, er});
    stall(n);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready) && n < 40);
    rready <= 1'b0;
    check("rdata", rdata, e);
    check("rresp", {30'h0, rresp}, {30'h0, er});
    stall(n);
  endtask

  task automatic st(input logic [7:0] e);
    rd(`CU_STATUS_ADDR, {24'h0, e}, `CU_RESP_OKAY);
  endtask

  task automatic por;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  task automatic t_regs;
    st(8'h60);
    rd(`CU_ENABLE_ADDR, 32'h0, `CU_RESP_OKAY);
    wr(`CU_ENABLE_ADDR, 8'hff, 4'h1, `CU_RESP_OKAY);
    rd(`CU_ENABLE_ADDR, 32'h92, `CU_RESP_OKAY);
    wr(`CU_ENABLE_ADDR, 8'h00, 4'h0, `CU_RESP_OKAY);
    rd(`CU_ENABLE_ADDR, 32'h92, `CU_RESP_OKAY);
    wr(12'h100, 8'hff, 4'h1, `CU_RESP_SLVERR);
    rd(12'h100, 32'h0, `CU_RESP_SLVERR);
    wr(`CU_ENABLE_ADDR, 8'h80, 4'h1, `CU_RESP_OKAY);
  endtask

  task automatic t_tick;
    tick <= 1'b1;
    @(posedge aclk);
    tick <= 1'b0;
    repeat (2) @(posedge aclk);
    check("tick_irq", {31'h0, tick_irq}, 32'h1);
    st(8'he0);
    wr(`CU_STATUS_ADDR, 8'h00, 4'h1, `CU_RESP_OKAY);
    st(8'he0);
    wr(`CU_ENABLE_ADDR, 8'h00, 4'h1, `CU_RESP_OKAY);
    check("tick_irq", {31'h0, tick_irq}, 32'h0);
    wr(`CU_STATUS_ADDR, 8'h80, 4'h1, `CU_RESP_OKAY);
    st(8'h60);
  endtask

  task automatic t_pll;
    div      <= 5'h07;
    lock_raw <= 1'b1;
    repeat (8) @(posedge aclk);
    check("ratio", {26'h0, ratio}, 32'h8);
    st(8'h78);
    wr(`CU_ENABLE_ADDR, 8'h12, 4'h1, `CU_RESP_OKAY);
    check("pll_irq", {31'h0, pll_irq}, 32'h1);
    wr(`CU_STATUS_ADDR, 8'h10, 4'h1, `CU_RESP_OKAY);
    check("pll_irq", {31'h0, pll_irq}, 32'h0);
    qual_raw <= 1'b1;
    repeat (8) @(posedge aclk);
    check("xen", {31'h0, xen}, 32'h1);
    check("x_irq", {31'h0, x_irq}, 32'h1);
    wr(`CU_STATUS_ADDR, 8'h0b, 4'h1, `CU_RESP_OKAY);
    st(8'h69);
    lock_raw <= 1'b0;
    repeat (8) @(posedge aclk);
    st(8'h72);
    check("ratio", {26'h0, ratio}, 32'h4);
  endtask

  task automatic t_modes;
    qual_raw <= 1'b0;
    lock_raw <= 1'b1;
    psel     <= 1'b1;
    repeat (8) @(posedge aclk);
    qual_raw <= 1'b1;
    repeat (8) @(posedge aclk);
    check("xen", {31'h0, xen}, 32'h1);
    check("bus_half", {31'h0, bus_half}, 32'h1);
    check("pll_run", {31'h0, prun}, 32'h1);
    fstop <= 1'b1;
    @(posedge aclk);
    fstop <= 1'b0;
    repeat (2) @(posedge aclk);
    check("xen", {31'h0, xen}, 32'h0);
    synth <= 1'b1;
    @(posedge aclk);
    synth <= 1'b0;
    repeat (3) @(posedge aclk);
    st(8'h72);
  endtask

  task automatic t_sysrst;
    lock_raw <= 1'b0;
    qual_raw <= 1'b0;
    repeat (8) @(posedge aclk);
    wr(`CU_STATUS_ADDR, 8'hff, 4'h1, `CU_RESP_OKAY);
    st(8'h00);
    lowvolt     <= 1'b1;
    badaddr     <= 1'b1;
    sys_reset_n <= 1'b0;
    repeat (3) @(posedge aclk);
    sys_reset_n <= 1'b1;
    lowvolt     <= 1'b0;
    badaddr     <= 1'b0;
    repeat (6) @(posedge aclk);
    st(8'h24);
    por();
    st(8'h60);
  endtask

  // Lock lost while entering pseudo stop must keep the qualified status.
  task automatic t_pstop;
    {lock_raw, qual_raw} <= 2'b11;
    repeat (8) @(posedge aclk);
    {pstop, lock_raw} <= 2'b10;
    repeat (8) @(posedge aclk);
    pstop <= 1'b0;
    check("xen", {31'h0, xen}, 32'h1);
    st(8'h73);
  endtask

  // Inputs settle at time zero; everything later moves on clock edges.
  initial begin
    {aresetn, sys_reset_n} = 2'b01;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
    {tick, lowvolt, badaddr, fstop, pstop, synth, psel, lock_raw, qual_raw} = 9'h0;
    div = 5'h00;
    err_total = 0;
    n_checks = 0;
    por();
    t_regs();
    t_tick();
    t_pll();
    t_modes();
    t_sysrst();
    t_pstop();
    summarize();
  end
endmodule
